// ===== logic/rxo_stream_out.sv
// Purpose: Presents received frames to client logic as a stream master
// Assumes: Upstream words are contiguous, lane 0 first, FCS included,
//          with at least two idle input cycles after each last word
// Notes:   No ready input; the client must take every valid transfer
`timescale 1ns/10ps
`include "rxo_regs.svh"
`default_nettype none

// What this block does
// - Client port width is 64 or 32 bits.
// - One keep bit per byte lane.
// - All client outputs driven from core clock.
// - Active low reset clears the stream path.
// - Status low on bad, high on good.
// - Lane n is bits 8n+7 down to 8n.
// - Frame data can leave with idle cycles between transfers.
// - Valid high whenever frame data is shown.
// - Keep all ones except on final transfer.
// - Final valid bytes start at lane 0.
// - Last and status only after all checks.
// - Last high for one cycle per frame.
// - Final transfer holds at least one byte.
// - Idle cycles allowed before final status.
// - Padding dropped by holding valid low.
// - Bytes past length field are padding unless FCS passed.
// - Short length field, frame not 64 bytes, is bad.
// - Status of a frame precedes next frame data.
// - Frames under 64 bytes are bad.
// - FCS failure marks frame bad.
// - Oversize frames bad unless jumbo enabled.
// - FCS passing keeps padding for client.
module rxo_stream_out #(
   parameter int DATA_BYTES = `RXO_DATA_BYTES
) (
   input  wire logic                    core_clk,
   input  wire logic                    rst_b,
   input  wire logic                    clk_en,
   // Internal receive datapath
   input  wire logic                    rx_in_valid,
   input  wire logic [DATA_BYTES*8-1:0] rx_in_data,
   input  wire logic [DATA_BYTES-1:0]   rx_in_keep,
   input  wire logic                    rx_in_last,
   input  wire logic                    rx_in_code_err,
   input  wire logic                    rx_in_fcs_good,
   // Configuration enables
   input  wire logic                    cfg_fcs_pass_en,
   input  wire logic                    cfg_len_chk_en,
   input  wire logic                    cfg_jumbo_en,
   // Client stream
   output logic [DATA_BYTES*8-1:0]      rx_axis_tdata,
   output logic [DATA_BYTES-1:0]        rx_axis_tkeep,
   output logic                         rx_axis_tvalid,
   output logic                         rx_axis_tlast,
   output logic                         rx_axis_tuser
);

   localparam int DW = DATA_BYTES * 8;
   localparam int CW = `RXO_CNT_W;
   localparam logic [CW-1:0] WBYTES = CW'(DATA_BYTES);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   rxo_pkg::rxo_state_type state_reg;
   rxo_pkg::rxo_state_type state_next;

   logic [DW-1:0]         s0_data_reg;
   logic [DW-1:0]         s1_data_reg;
   logic [CW-1:0]         s0_start_reg;
   logic [CW-1:0]         s1_start_reg;
   logic                  s0_vld_reg;
   logic                  s1_vld_reg;
   logic [CW-1:0]         cnt_reg;
   logic [`RXO_LT_W-1:0]  lt_reg;
   logic                  err_reg;
   logic [DW-1:0]         fin_data_reg;
   logic [DATA_BYTES-1:0] fin_keep_reg;
   logic                  fin_vld_reg;
   logic [CW-1:0]         dlim_reg;
   logic                  good_reg;

   // ----------------------------------------------------------------
   // Input word accounting
   // ----------------------------------------------------------------

   // Count of valid bytes in an input word
   function automatic logic [CW-1:0] rxo_byte_count(input logic [DATA_BYTES-1:0] k);
      logic [CW-1:0] n;
      n = '0;
      for (int i = 0; i < DATA_BYTES; i++) begin
         n = n + CW'(k[i]);
      end
      return n;
   endfunction

   wire logic            push     = clk_en & rx_in_valid & (state_reg == rxo_pkg::RXO_ST_IDLE);
   wire logic            push_end = push & rx_in_last;
   wire logic [CW-1:0]   in_bytes = rxo_byte_count(rx_in_keep);
   wire logic [CW-1:0]   total    = cnt_reg + in_bytes;
   wire logic            lt_known = cnt_reg > `RXO_LT_LO_POS;

   // Length/type byte capture, one slice per lane
   logic [7:0] lt_hi_acc [DATA_BYTES+1];
   logic [7:0] lt_lo_acc [DATA_BYTES+1];
   logic [DATA_BYTES:0] hi_hit_acc;
   logic [DATA_BYTES:0] lo_hit_acc;
   assign lt_hi_acc[0]  = 8'h00;
   assign lt_lo_acc[0]  = 8'h00;
   assign hi_hit_acc[0] = 1'b0;
   assign lo_hit_acc[0] = 1'b0;

   genvar gl;
   generate
      for (gl = 0; gl < DATA_BYTES; gl++) begin : g_lane
         wire logic [CW-1:0] pos    = cnt_reg + CW'(gl);
         wire logic          hi_hit = rx_in_keep[gl] && (pos == `RXO_LT_HI_POS);
         wire logic          lo_hit = rx_in_keep[gl] && (pos == `RXO_LT_LO_POS);
         wire logic [7:0]    lane   = rx_in_data[gl*8 +: 8];
         assign lt_hi_acc[gl+1]  = lt_hi_acc[gl] | (hi_hit ? lane : 8'h00);
         assign lt_lo_acc[gl+1]  = lt_lo_acc[gl] | (lo_hit ? lane : 8'h00);
         assign hi_hit_acc[gl+1] = hi_hit_acc[gl] | hi_hit;
         assign lo_hit_acc[gl+1] = lo_hit_acc[gl] | lo_hit;
      end
   endgenerate

   wire logic [`RXO_LT_W-1:0] lt_next = {hi_hit_acc[DATA_BYTES] ? lt_hi_acc[DATA_BYTES] : lt_reg[15:8],
                                         lo_hit_acc[DATA_BYTES] ? lt_lo_acc[DATA_BYTES] : lt_reg[7:0]};

   // ----------------------------------------------------------------
   // Delivery limits
   // ----------------------------------------------------------------

   // Bytes past the length field are padding; kept when FCS is passed
   wire logic is_len  = lt_reg < `RXO_LT_TYPE_MIN;
   wire logic is_vlan = lt_reg == `RXO_VLAN_TPID;
   wire logic [CW-1:0] len_lim = (lt_known && is_len && !cfg_fcs_pass_en) ?
                                 (CW'(lt_reg) + `RXO_HDR_BYTES) : `RXO_NO_LIMIT;

   // Final data limit at frame end: FCS stripped unless passed, never zero
   wire logic [CW-1:0] fcs_lim  = cfg_fcs_pass_en ? total :
                                  ((total > `RXO_FCS_BYTES) ? (total - `RXO_FCS_BYTES) : CW'(1));
   wire logic [CW-1:0] end_lim  = (len_lim < fcs_lim) ? len_lim : fcs_lim;

   // Frame checks, all resolved in the cycle of the last input word
   wire logic [CW-1:0] max_len  = is_vlan ? `RXO_MAX_TAG : `RXO_MAX_UNTAG;
   wire logic bad_fcs   = !rx_in_fcs_good;
   wire logic bad_short = total < `RXO_MIN_FRAME;
   wire logic bad_long  = !cfg_jumbo_en && (total > max_len);
   wire logic bad_pad   = cfg_len_chk_en && (lt_reg < `RXO_LT_MIN_LEN) &&
                          (total != `RXO_MIN_FRAME);
   wire logic bad_trunc = cfg_len_chk_en && is_len && (lt_reg >= `RXO_LT_MIN_LEN) &&
                          (total < CW'(lt_reg) + `RXO_OVH_BYTES);
   wire logic bad_code  = err_reg | rx_in_code_err;
   wire logic frame_good = !(bad_fcs | bad_short | bad_long | bad_pad | bad_trunc | bad_code);

   // ----------------------------------------------------------------
   // Word decision: which held word leaves, and against what limit
   // ----------------------------------------------------------------
   wire logic          dec_s0   = state_reg == rxo_pkg::RXO_ST_DRAIN2;
   wire logic [DW-1:0] dec_data = dec_s0 ? s0_data_reg : s1_data_reg;
   wire logic [CW-1:0] dec_st   = dec_s0 ? s0_start_reg : s1_start_reg;
   wire logic          dec_vld  = dec_s0 ? s0_vld_reg : s1_vld_reg;
   wire logic [CW-1:0] dec_lim  = (state_reg == rxo_pkg::RXO_ST_IDLE) ? len_lim : dlim_reg;
   wire logic [CW-1:0] dec_end  = dec_st + WBYTES;

   // Whole word ahead of the limit, or the word the limit falls in
   wire logic          dec_full = dec_vld && (dec_end < dec_lim);
   wire logic          dec_fin  = dec_vld && (dec_st < dec_lim) && (dec_end >= dec_lim);
   wire logic [CW-1:0] dec_cnt  = dec_lim - dec_st;

   // Final keep fills from lane 0 upward
   logic [DATA_BYTES-1:0] dec_keep;
   genvar gk;
   generate
      for (gk = 0; gk < DATA_BYTES; gk++) begin : g_keep
         assign dec_keep[gk] = CW'(gk) < dec_cnt;
      end
   endgenerate

   // ----------------------------------------------------------------
   // Sequencing
   // ----------------------------------------------------------------

   // Drain held words after the last input word, then return to idle
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         rxo_pkg::RXO_ST_IDLE: begin
            if (push_end) begin
               state_next = rxo_pkg::RXO_ST_DRAIN1;
            end
         end
         rxo_pkg::RXO_ST_DRAIN1: begin
            if (fin_vld_reg || dec_fin) begin
               state_next = rxo_pkg::RXO_ST_IDLE;
            end else begin
               state_next = rxo_pkg::RXO_ST_DRAIN2;
            end
         end
         rxo_pkg::RXO_ST_DRAIN2: begin
            state_next = rxo_pkg::RXO_ST_IDLE;
         end
         default: begin
            state_next = rxo_pkg::RXO_ST_IDLE;
         end
      endcase
   end

   wire logic draining = state_reg != rxo_pkg::RXO_ST_IDLE;
   wire logic emit_fin = draining && fin_vld_reg;
   wire logic emit_end = draining && !fin_vld_reg && dec_fin;
   wire logic frame_done = clk_en && (state_next == rxo_pkg::RXO_ST_IDLE) && draining;

   // State register and two-deep hold pipeline
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= rxo_pkg::RXO_ST_IDLE;
         s0_vld_reg <= 1'b0;
         s1_vld_reg <= 1'b0;
         s0_data_reg <= '0;
         s1_data_reg <= '0;
         s0_start_reg <= '0;
         s1_start_reg <= '0;
      end else if (clk_en) begin
         state_reg <= state_next;
         if (push) begin
            s1_vld_reg <= s0_vld_reg;
            s1_data_reg <= s0_data_reg;
            s1_start_reg <= s0_start_reg;
            s0_vld_reg <= 1'b1;
            s0_data_reg <= rx_in_data;
            s0_start_reg <= cnt_reg;
         end else if (frame_done) begin
            s0_vld_reg <= 1'b0;
            s1_vld_reg <= 1'b0;
         end
      end
   end

   // Per-frame counters, length field and sticky code error
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg <= '0;
         lt_reg <= '0;
         err_reg <= 1'b0;
      end else if (clk_en) begin
         if (push_end) begin
            cnt_reg <= '0;
         end else if (push) begin
            cnt_reg <= total;
            lt_reg <= lt_next;
            err_reg <= err_reg | rx_in_code_err;
         end
         if (frame_done) begin
            err_reg <= 1'b0;
            lt_reg <= '0;
         end
      end
   end

   // Frame end results and the held final word
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         dlim_reg <= '0;
         good_reg <= 1'b0;
         fin_vld_reg <= 1'b0;
         fin_data_reg <= '0;
         fin_keep_reg <= '0;
      end else if (clk_en) begin
         if (push_end) begin
            dlim_reg <= end_lim;
            good_reg <= frame_good;
         end
         if (push && dec_fin) begin
            fin_vld_reg <= 1'b1;
            fin_data_reg <= dec_data;
            fin_keep_reg <= dec_keep;
         end else if (frame_done) begin
            fin_vld_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Client outputs
   // ----------------------------------------------------------------

   // Words before the limit go out full, padding and FCS are withheld
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_axis_tvalid <= 1'b0;
         rx_axis_tlast <= 1'b0;
         rx_axis_tuser <= 1'b0;
         rx_axis_tdata <= '0;
         rx_axis_tkeep <= '0;
      end else if (clk_en) begin
         rx_axis_tlast <= 1'b0;
         rx_axis_tuser <= 1'b0;
         if (emit_fin) begin
            rx_axis_tvalid <= 1'b1;
            rx_axis_tlast <= 1'b1;
            rx_axis_tuser <= good_reg;
            rx_axis_tdata <= fin_data_reg;
            rx_axis_tkeep <= fin_keep_reg;
         end else if (emit_end) begin
            rx_axis_tvalid <= 1'b1;
            rx_axis_tlast <= 1'b1;
            rx_axis_tuser <= good_reg;
            rx_axis_tdata <= dec_data;
            rx_axis_tkeep <= dec_keep;
         end else if ((push || draining) && dec_full) begin
            rx_axis_tvalid <= 1'b1;
            rx_axis_tdata <= dec_data;
            rx_axis_tkeep <= '1;
         end else begin
            rx_axis_tvalid <= 1'b0;
         end
      end
   end

endmodule

`default_nettype wire

// ===== common/rxo_regs.svh
// Purpose: Constants for the receive client stream output stage
// Assumes: Byte counts are in octets, frame length counts DA through FCS
// Notes:   Definitions only
`ifndef RXO_REGS_SVH
`define RXO_REGS_SVH

`define RXO_DATA_BYTES   8          // Lanes on the client port, 8 or 4
`define RXO_CNT_W        17         // Frame byte counter width
`define RXO_LT_W         16         // Length/type field width
`define RXO_FCS_BYTES    17'h00004  // FCS length
`define RXO_HDR_BYTES    17'h0000E  // DA, SA and length/type
`define RXO_OVH_BYTES    17'h00012  // Header plus FCS
`define RXO_LT_HI_POS    17'h0000C  // Offset of length/type upper byte
`define RXO_LT_LO_POS    17'h0000D  // Offset of length/type lower byte
`define RXO_MIN_FRAME    17'h00040  // Minimum legal frame, 64 bytes
`define RXO_LT_MIN_LEN   16'h002E   // Length values below 46 need padding
`define RXO_LT_TYPE_MIN  16'h0600   // Values from here on are types
`define RXO_VLAN_TPID    16'h8100   // Tagged frame marker
`define RXO_MAX_UNTAG    17'h005EE  // 1518 bytes
`define RXO_MAX_TAG      17'h005F2  // 1522 bytes
`define RXO_NO_LIMIT     17'h1FFFF  // No length limit in force

`endif

// ===== common/rxo_pkg.sv
// Purpose: Types for the receive client stream output stage
// Assumes: Used with rxo_regs.svh
// Notes:   Types only
`default_nettype none

package rxo_pkg;

   // Output sequencing state
   typedef enum logic [1:0] {
      RXO_ST_IDLE   = 2'b00,
      RXO_ST_DRAIN1 = 2'b01,
      RXO_ST_DRAIN2 = 2'b10
   } rxo_state_type;

endpackage

`default_nettype wire

// ===== tb/rxo_stream_out_checker.sv
// Purpose: Assertions on the client stream port
// Assumes: Sees the top module ports only
// Notes:   Bound to every rxo_stream_out
`timescale 1ns/10ps
`default_nettype none
module rxo_checker #(
   parameter int DATA_BYTES = 8
) (
   input wire logic                    core_clk,
   input wire logic                    rst_b,
   input wire logic                    clk_en,
   input wire logic                    rx_in_valid,
   input wire logic [DATA_BYTES*8-1:0] rx_in_data,
   input wire logic [DATA_BYTES-1:0]   rx_in_keep,
   input wire logic                    rx_in_last,
   input wire logic                    rx_in_code_err,
   input wire logic                    rx_in_fcs_good,
   input wire logic                    cfg_fcs_pass_en,
   input wire logic                    cfg_len_chk_en,
   input wire logic                    cfg_jumbo_en,
   input wire logic [DATA_BYTES*8-1:0] rx_axis_tdata,
   input wire logic [DATA_BYTES-1:0]   rx_axis_tkeep,
   input wire logic                    rx_axis_tvalid,
   input wire logic                    rx_axis_tlast,
   input wire logic                    rx_axis_tuser
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // Lane qualifiers on each transfer
   keep_full_a: assert property (rx_axis_tvalid && !rx_axis_tlast |-> &rx_axis_tkeep)
      else $error("Keep not full before the last transfer");
   keep_nonzero_a: assert property (rx_axis_tvalid && rx_axis_tlast |-> |rx_axis_tkeep)
      else $error("Last transfer carries no byte");
   keep_contig_a: assert property (rx_axis_tlast |-> (rx_axis_tkeep & (rx_axis_tkeep + 1'h1)) == '0)
      else $error("Last keep not contiguous from lane 0");
   // End marker and status
   last_pulse_a: assert property (rx_axis_tlast && clk_en |=> !rx_axis_tlast)
      else $error("Last held for more than one cycle");
   last_valid_a: assert property (rx_axis_tlast |-> rx_axis_tvalid)
      else $error("Last without valid");
   user_idle_a: assert property (!rx_axis_tlast |-> !rx_axis_tuser)
      else $error("Status high away from last");
   end_latency_a: assert property (rx_in_valid && rx_in_last && clk_en |-> ##[1:8] rx_axis_tlast)
      else $error("Frame end not reported in time");
   bad_fcs_a: assert property (rx_in_valid && rx_in_last && clk_en && !rx_in_fcs_good
      |-> ##[1:8] rx_axis_tlast && !rx_axis_tuser) else $error("Bad check sum not reported");
   // Reset and clock enable
   reset_quiet_a: assert property ($rose(rst_b) |-> !rx_axis_tvalid && !rx_axis_tlast)
      else $error("Outputs active out of reset");
   hold_frozen_a: assert property (!clk_en |=> $stable(rx_axis_tvalid) && $stable(rx_axis_tdata))
      else $error("Outputs moved while clock disabled");
endmodule
bind rxo_stream_out rxo_checker #(.DATA_BYTES(DATA_BYTES)) u_rxo_chk (
   .core_clk, .rst_b, .clk_en, .rx_in_valid, .rx_in_data, .rx_in_keep, .rx_in_last, .rx_in_code_err,
   .rx_in_fcs_good, .cfg_fcs_pass_en, .cfg_len_chk_en, .cfg_jumbo_en, .rx_axis_tdata, .rx_axis_tkeep,
   .rx_axis_tvalid, .rx_axis_tlast, .rx_axis_tuser);
`default_nettype wire

// ===== tb/rxo_client_model.sv
// Purpose: Client logic that takes every received transfer
// Assumes: No ready path, beats count only with clk_en
// Notes:   Reports length, status and a weighted byte sum
`timescale 1ns/10ps
`default_nettype none
module rxo_client_model #(
   parameter int DATA_BYTES = 8
) (
   input wire logic                    core_clk,
   input wire logic                    rst_b,
   input wire logic                    clk_en,
   input wire logic [DATA_BYTES*8-1:0] rx_axis_tdata,
   input wire logic [DATA_BYTES-1:0]   rx_axis_tkeep,
   input wire logic                    rx_axis_tvalid,
   input wire logic                    rx_axis_tlast,
   input wire logic                    rx_axis_tuser,
   output logic [15:0]                 frames,
   output logic [15:0]                 got_len,
   output logic                        got_good,
   output logic [31:0]                 got_sum
);
   logic [15:0] cnt;
   logic [31:0] acc;
   // Takes each valid beat at once, it cannot stall
   always_ff @(posedge core_clk or negedge rst_b) begin
      logic [15:0] c;
      logic [31:0] a;
      if (!rst_b) begin
         frames <= 16'h0000;
         cnt <= 16'h0000;
         acc <= 32'h00000000;
      end else if (clk_en && rx_axis_tvalid) begin
         c = cnt;
         a = acc;
         for (int i = 0; i < DATA_BYTES; i++) begin
            if (rx_axis_tkeep[i]) begin
               c = c + 16'h0001;
               a = a + rx_axis_tdata[8*i+:8] * c;
            end
         end
         if (rx_axis_tlast) begin
            got_len <= c;
            got_good <= rx_axis_tuser;
            got_sum <= a;
            frames <= frames + 16'h0001;
            cnt <= 16'h0000;
            acc <= 32'h00000000;
         end else begin
            cnt <= c;
            acc <= a;
         end
      end
   end
endmodule
`default_nettype wire

// ===== tb/test_rx_client_stream_output.sv
// Purpose: Self-checking bench for the receive client output stage
// Assumes: 64-bit port, inputs driven on the falling edge
// Notes:   Expected length, status and sum come from frame settings
`timescale 1ns/10ps
`include "rxo_regs.svh"
`default_nettype none
module test_rx_client_stream_output;
   localparam int DB = 8;
   logic              core_clk = 1'h0;
   logic              rst_b = 1'h0;
   logic              clk_en = 1'h1;
   logic              rx_in_valid = 1'h0;
   logic [DB*8-1:0]   rx_in_data = '0;
   logic [DB-1:0]     rx_in_keep = '0;
   logic              rx_in_last = 1'h0;
   logic              rx_in_code_err = 1'h0;
   logic              rx_in_fcs_good = 1'h0;
   logic              cfg_fcs_pass_en = 1'h0;
   logic              cfg_len_chk_en = 1'h0;
   logic              cfg_jumbo_en = 1'h0;
   logic [DB*8-1:0]   rx_axis_tdata;
   logic [DB-1:0]     rx_axis_tkeep;
   logic              rx_axis_tvalid;
   logic              rx_axis_tlast;
   logic              rx_axis_tuser;
   logic [15:0]       frames;
   logic [15:0]       got_len;
   logic              got_good;
   logic [31:0]       got_sum;
   int                mismatches = 0;
   int                n_compared = 0;
   // ---------------------------------
   // Clock, design and client
   // ---------------------------------
   always #25 core_clk = ~core_clk;
   rxo_stream_out #(.DATA_BYTES(DB)) DUT (.core_clk, .rst_b, .clk_en, .rx_in_valid, .rx_in_data,
      .rx_in_keep, .rx_in_last, .rx_in_code_err, .rx_in_fcs_good, .cfg_fcs_pass_en, .cfg_len_chk_en,
      .cfg_jumbo_en, .rx_axis_tdata, .rx_axis_tkeep, .rx_axis_tvalid, .rx_axis_tlast, .rx_axis_tuser);
   rxo_client_model #(.DATA_BYTES(DB)) u_client (.core_clk, .rst_b, .clk_en, .rx_axis_tdata,
      .rx_axis_tkeep, .rx_axis_tvalid, .rx_axis_tlast, .rx_axis_tuser, .frames, .got_len, .got_good, .got_sum);
   // ---------------------------------
   // Shared tasks
   // ---------------------------------
   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask
   // Frame byte k, with the length/type field at bytes 12 and 13
   function automatic logic [7:0] bval(input int k, input logic [15:0] lt);
      return k == 12 ? lt[15:8] : k == 13 ? lt[7:0] : 8'(k * 7 + 1);
   endfunction
   task automatic cfg(input logic pass, input logic chk, input logic jumbo);
      @(negedge core_clk);
      cfg_fcs_pass_en = pass;
      cfg_len_chk_en = chk;
      cfg_jumbo_en = jumbo;
   endtask
   // Sends one frame, waits for its end and judges what the client got
   task automatic run_case(input int total, input logic [15:0] lt, input logic fcs, input logic err, input logic slow);
      int          exp_len;
      logic        exp_good;
      logic [31:0] exp_sum;
      logic [15:0] seen_frames;
      int          n;
      exp_len = cfg_fcs_pass_en ? total : total - 4;
      if (!cfg_fcs_pass_en && lt < 16'h0600 && lt + 14 < exp_len) exp_len = lt + 14;
      exp_good = fcs && !err && total >= 64 && (cfg_jumbo_en || total <= (lt == 16'h8100 ? 1522 : 1518));
      if (cfg_len_chk_en && lt < 16'h0600 && (lt < 46 ? total != 64 : total < lt + 18)) exp_good = 1'h0;
      exp_sum = '0;
      for (int k = 0; k < exp_len; k++) exp_sum = exp_sum + bval(k, lt) * (k + 1);
      seen_frames = frames;
      for (int w = 0; w * DB < total; w++) begin
         @(negedge core_clk);
         if (slow) begin
            clk_en = 1'h0;
            @(negedge core_clk);
         end
         clk_en = 1'h1;
         rx_in_valid = 1'h1;
         rx_in_last = (w + 1) * DB >= total;
         rx_in_fcs_good = fcs;
         rx_in_code_err = err;
         for (int i = 0; i < DB; i++) begin
            rx_in_keep[i] = w * DB + i < total;
            rx_in_data[8*i+:8] = bval(w * DB + i, lt);
         end
      end
      @(negedge core_clk);
      rx_in_valid = 1'h0;
      rx_in_last = 1'h0;
      for (n = 0; n < 40 && frames == seen_frames; n++) @(negedge core_clk);
      if (frames == seen_frames) begin
         mismatches++;
         $display("CHECK FAILED at %0t: frame end never seen", $time);
         tally_and_finish;
      end else begin
         check(got_len, exp_len, "length");
         check(got_good, exp_good, "status");
         check(got_sum, exp_sum, "content");
         repeat (2) @(negedge core_clk);
      end
   endtask
   // ---------------------------------
   // Scenarios
   // ---------------------------------
   task automatic t_type_frames;
      cfg(1'h0, 1'h1, 1'h0);
      for (int t = 70; t < 78; t++) run_case(t, 16'h0800, 1'h1, 1'h0, 1'h0);
   endtask
   task automatic t_padding;
      cfg(1'h0, 1'h1, 1'h0);
      run_case(64, 16'h0010, 1'h1, 1'h0, 1'h0);
      run_case(70, 16'h0010, 1'h1, 1'h0, 1'h0);
      run_case(64, 16'h002E, 1'h1, 1'h0, 1'h0);
      cfg(1'h0, 1'h0, 1'h0);
      run_case(70, 16'h0010, 1'h1, 1'h0, 1'h0);
      cfg(1'h1, 1'h1, 1'h0);
      run_case(64, 16'h0010, 1'h1, 1'h0, 1'h0);
   endtask
   task automatic t_bad_frames;
      cfg(1'h0, 1'h1, 1'h0);
      run_case(80, 16'h0800, 1'h0, 1'h0, 1'h0);
      run_case(80, 16'h0800, 1'h1, 1'h1, 1'h0);
      run_case(60, 16'h0800, 1'h1, 1'h0, 1'h0);
   endtask
   task automatic t_oversize;
      cfg(1'h0, 1'h1, 1'h0);
      run_case(1519, 16'h0800, 1'h1, 1'h0, 1'h0);
      run_case(1522, 16'h8100, 1'h1, 1'h0, 1'h0);
      run_case(1523, 16'h8100, 1'h1, 1'h0, 1'h0);
      cfg(1'h0, 1'h1, 1'h1);
      run_case(1519, 16'h0800, 1'h1, 1'h0, 1'h0);
   endtask
   task automatic t_slow_and_reset;
      cfg(1'h0, 1'h1, 1'h0);
      run_case(75, 16'h0800, 1'h1, 1'h0, 1'h1);
      @(negedge core_clk);
      rx_in_valid = 1'h1;
      rx_in_keep = '1;
      repeat (4) @(negedge core_clk);
      rst_b = 1'h0;
      @(negedge core_clk);
      check(rx_axis_tvalid, 1'h0, "valid in reset");
      check(rx_axis_tlast, 1'h0, "last in reset");
      rx_in_valid = 1'h0;
      rst_b = 1'h1;
      run_case(70, 16'h0800, 1'h1, 1'h0, 1'h0);
   endtask
   // Main sequence
   initial begin
      repeat (2) @(negedge core_clk);
      rst_b = 1'h1;
      t_type_frames();
      t_padding();
      t_bad_frames();
      t_oversize();
      t_slow_and_reset();
      tally_and_finish();
   end
endmodule
`default_nettype wire
